// ### design/vtf_formatter.sv
/*
 Video timing formatter top: line and field counting, timing code insertion,
 sample quantising and multiplexing, and an AXI4-Lite control slave.
 Assumes a sample source on ref_clk that holds each sample until vid_req
 takes it, and one destination that decodes the link words.
*/
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vtf_defines.svh"

module vtf_formatter (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [3:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [3:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire vtf_pkg::vtf_pix_t pix_in,
    output logic                   vid_req,
    output vtf_pkg::vtf_link_t     link_data,
    output logic                   link_clk,
    output logic                   sync_ref
);
    vtf_pkg::vtf_cfg_t   ctrl;
    vtf_pkg::vtf_cfg_t   cfg;
    vtf_pkg::vtf_seg_t   seg;
    vtf_pkg::vtf_flags_t flags;
    logic [3:0]          aw_addr;
    logic                aw_full;
    logic                w_full;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                wr_fire;
    logic [11:0]         hc;
    logic [11:0]         next_hc;
    logic [10:0]         lc;
    logic [10:0]         next_lc;
    logic                fld;
    logic                vbl;
    logic                cur_fld;
    logic                cur_vbl;
    logic                frame_end;
    logic                video_on;
    logic                next_video_on;
    logic [31:0]         status;
    logic [9:0]          smp [3];
    logic [9:0]          blk [3];
    logic [9:0]          wd  [3];

    // ==========================================================
    // Timing lookups per line system
    function automatic logic [11:0] line_len(input logic s1250);
        line_len = s1250 ? `VTF_LINE_1250 : `VTF_LINE_1125;
    endfunction : line_len

    function automatic logic [11:0] blank_len(input logic s1250);
        blank_len = s1250 ? `VTF_BLANK_1250 : `VTF_BLANK_1125;
    endfunction : blank_len

    function automatic logic [11:0] eav_lead(input logic s1250);
        eav_lead = s1250 ? `VTF_EAV_LEAD_1250 : `VTF_EAV_LEAD_1125;
    endfunction : eav_lead

    function automatic logic [11:0] sav_lag(input logic s1250);
        sav_lag = s1250 ? `VTF_SAV_LAG_1250 : `VTF_SAV_LAG_1125;
    endfunction : sav_lag

    function automatic logic [10:0] last_line(input logic s1250);
        last_line = s1250 ? `VTF_LAST_1250 : `VTF_LAST_1125;
    endfunction : last_line

    function automatic logic [10:0] field2_start(input logic s1250);
        field2_start = s1250 ? `VTF_F2_START_1250 : `VTF_F2_START_1125;
    endfunction : field2_start

    function automatic logic in_active(input logic [10:0] ln, input logic s1250);
        if (s1250) begin
            in_active = (ln >= `VTF_F1_ACT_1250 && ln <= `VTF_F1_END_1250)
                     || (ln >= `VTF_F2_ACT_1250 && ln <= `VTF_F2_END_1250);
        end else begin
            in_active = (ln >= `VTF_F1_ACT_1125 && ln <= `VTF_F1_END_1125)
                     || (ln >= `VTF_F2_ACT_1125 && ln <= `VTF_F2_END_1125);
        end
    endfunction : in_active

    // ==========================================================
    // AXI4-Lite write channel; address and data in either order
    assign wr_fire = aw_full && w_full && !bvalid;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `VTF_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full <= 1'b1;
                aw_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                bvalid  <= 1'b1;
                if (aw_addr == `VTF_REG_CTRL || aw_addr == `VTF_REG_STAT) begin
                    bresp <= `VTF_RESP_OKAY;
                end else begin
                    bresp <= `VTF_RESP_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Control register: enable, line system, word width, RGB mode
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= '0;
        end else if (wr_fire && aw_addr == `VTF_REG_CTRL && w_strb[0]) begin
            ctrl <= vtf_pkg::vtf_cfg_t'(w_data[`VTF_CTRL_W-1:0]);
        end
    end

    // ==========================================================
    // AXI4-Lite read channel; answer one cycle after the address
    assign status = {13'h0, cfg.enable, vbl, fld, 5'h0, lc};

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `VTF_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `VTF_RESP_OKAY;
            case (araddr)
                `VTF_REG_CTRL: rdata <= {28'h0, ctrl};
                `VTF_REG_STAT: rdata <= status;
                default: begin
                    rdata <= 32'h0;
                    rresp <= `VTF_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // Working configuration; mode changes wait for a frame edge so a
    // running picture is never cut mid-frame, but disable acts at once
    assign frame_end = (hc == line_len(cfg.sys1250) - 12'h001) && (lc == last_line(cfg.sys1250));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= '0;
        end else if (!ctrl.enable || !cfg.enable || frame_end) begin
            cfg <= ctrl;
        end
    end

    // ==========================================================
    // Sample and line counters; the sample clock is ref_clk
    always_comb begin
        next_hc = hc + 12'h001;
        next_lc = lc;
        if (!cfg.enable) begin
            next_hc = 12'h000;
            next_lc = `VTF_FIRST_LINE;
        end else if (hc == line_len(cfg.sys1250) - 12'h001) begin
            next_hc = 12'h000;
            if (lc == last_line(cfg.sys1250)) begin
                next_lc = `VTF_FIRST_LINE;
            end else begin
                next_lc = lc + 11'h001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hc <= 12'h000;
            lc <= `VTF_FIRST_LINE;
        end else begin
            hc <= next_hc;
            lc <= next_lc;
        end
    end

    // ==========================================================
    // Line segments: end code opens the line, start code closes blanking
    always_comb begin
        seg = vtf_pkg::SEG_BLANK;
        if (hc < `VTF_CODE_LEN) begin
            seg = vtf_pkg::SEG_EAV;
        end else if (hc >= blank_len(cfg.sys1250)) begin
            seg = vtf_pkg::SEG_ACTIVE;
        end else if (hc >= blank_len(cfg.sys1250) - `VTF_CODE_LEN) begin
            seg = vtf_pkg::SEG_SAV;
        end
    end

    // Field and frame-blank flags are taken only at the line start
    assign cur_fld = (hc == 12'h000) ? (lc >= field2_start(cfg.sys1250)) : fld;
    assign cur_vbl = (hc == 12'h000) ? !in_active(lc, cfg.sys1250) : vbl;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fld <= 1'b0;
            vbl <= 1'b1;
        end else if (!cfg.enable) begin
            fld <= 1'b0;
            vbl <= 1'b1;
        end else begin
            fld <= cur_fld;
            vbl <= cur_vbl;
        end
    end

    always_comb begin
        flags.f = cur_fld;
        flags.v = cur_vbl;
        flags.h = 1'b0;
        video_on = 1'b0;
        case (seg)
            vtf_pkg::SEG_EAV:    flags.h = 1'b1;
            vtf_pkg::SEG_SAV:    flags.h = 1'b0;
            vtf_pkg::SEG_ACTIVE: video_on = in_active(lc, cfg.sys1250);
            default:             flags.h = 1'b0;
        endcase
    end

    assign next_video_on = cfg.enable && next_hc >= blank_len(cfg.sys1250)
                        && in_active(next_lc, cfg.sys1250);

    // ==========================================================
    // Channel words; both blanking lengths are multiples of four, so
    // the low count bits index the code words
    always_comb begin
        smp[0] = pix_in.y_g;
        smp[1] = (cfg.rgb || !hc[0]) ? pix_in.cb_b : pix_in.cr_r;
        smp[2] = pix_in.cr_r;
        blk[0] = `VTF_BLACK;
        blk[1] = cfg.rgb ? `VTF_BLACK : `VTF_ACHROM;
        blk[2] = `VTF_BLACK;
    end

    for (genvar gi = 0; gi < 3; gi++) begin : g_ch
        vtf_word_fmt u_fmt (
            .is_code   (seg == vtf_pkg::SEG_EAV || seg == vtf_pkg::SEG_SAV),
            .code_idx  (hc[1:0]),
            .flags     (flags),
            .full_code (cfg.ten_bit || cfg.sys1250),
            .ten_bit   (cfg.ten_bit),
            .video_on  (video_on),
            .sample    (smp[gi]),
            .blank_lvl (blk[gi]),
            .word      (wd[gi])
        );
    end

    // ==========================================================
    // Link outputs; nothing comes back from the destination
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_data <= '0;
            link_clk  <= 1'b0;
            sync_ref  <= 1'b0;
            vid_req   <= 1'b0;
        end else if (!cfg.enable) begin
            link_data <= '0;
            link_clk  <= 1'b0;
            sync_ref  <= 1'b0;
            vid_req   <= next_video_on;
        end else begin
            link_data.y_ch <= wd[0];
            link_data.c_ch <= wd[1];
            link_data.x_ch <= cfg.rgb ? wd[2] : `VTF_ZERO;
            link_clk       <= !hc[0];
            sync_ref       <= (hc == eav_lead(cfg.sys1250));
            vid_req        <= next_video_on;
        end
    end

    // ==========================================================
    // Checks
    line_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && hc == line_len(cfg.sys1250) - 12'h001) |=> (hc == 12'h000))
        else $error("line did not wrap at its length");

    eav_code_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && hc == 12'h000)
        |=> (link_data.y_ch == ((cfg.ten_bit || cfg.sys1250) ? `VTF_PRE_10 : `VTF_PRE_8))
        ##1 (link_data.y_ch == `VTF_ZERO) ##1 (link_data.y_ch == `VTF_ZERO)
        ##1 (link_data.y_ch[9] && link_data.y_ch[6]))
        else $error("end code missing or malformed");

    sav_prot_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && hc == blank_len(cfg.sys1250) - 12'h001)
        |=> (!link_data.y_ch[6] && link_data.y_ch[5:2]
             == vtf_pkg::vtf_protect(vtf_pkg::vtf_flags_t'(link_data.y_ch[8:6]))))
        else $error("start code flag word wrong");

    sync_pos_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sync_ref |-> (hc == eav_lead(cfg.sys1250) + 12'h001))
        else $error("sync reference misplaced");

    act_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && $rose(vid_req)) |-> (hc == eav_lead(cfg.sys1250) + sav_lag(cfg.sys1250)))
        else $error("active video starts at wrong sample");

    video_range_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && $past(vid_req))
        |-> (link_data.y_ch >= `VTF_VID_MIN && link_data.y_ch <= `VTF_VID_MAX
             && link_data.c_ch >= `VTF_VID_MIN && link_data.c_ch <= `VTF_VID_MAX))
        else $error("video word in reserved range");

    flag_change_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && $past(cfg.enable) && ($changed(fld) || $changed(vbl)))
        |-> (hc == 12'h001))
        else $error("field flags changed mid-line");

    eight_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && !cfg.ten_bit && $past(vid_req))
        |-> (link_data.y_ch[1:0] == 2'h0 && link_data.c_ch[1:0] == 2'h0))
        else $error("8-bit sample has nonzero fraction");

    field_two_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && hc == 12'h001) |-> (fld == (lc >= field2_start(cfg.sys1250))))
        else $error("field flag wrong for line");

    vblank_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && hc == 12'h001) |-> (vbl == !in_active(lc, cfg.sys1250)))
        else $error("frame blank flag wrong for line");

    link_phase_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.enable && $past(cfg.enable) && $past(cfg.enable, 2))
        |-> (link_clk != $past(link_clk)))
        else $error("link clock did not toggle");
endmodule : vtf_formatter

`default_nettype wire

// ### design/vtf_word_fmt.sv
/*
 One link channel word: timing code, clamped video sample or blanking level.
 Assumes the caller registers the word and decodes the line position.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vtf_defines.svh"

module vtf_word_fmt (
    input  wire logic                is_code,
    input  wire logic [1:0]          code_idx,
    input  wire vtf_pkg::vtf_flags_t flags,
    input  wire logic                full_code,
    input  wire logic                ten_bit,
    input  wire logic                video_on,
    input  wire logic [9:0]          sample,
    input  wire logic [9:0]          blank_lvl,
    output logic [9:0]               word
);
    logic [9:0] clamped;

    // ==========================================================
    // Sample clamp, then truncate: keeps 8-bit words off 255
    always_comb begin
        clamped = sample;
        if (sample < `VTF_VID_MIN) begin
            clamped = `VTF_VID_MIN;
        end else if (sample > `VTF_VID_MAX) begin
            clamped = `VTF_VID_MAX;
        end
        if (!ten_bit) begin
            clamped[1:0] = 2'h0;
        end
    end

    // ==========================================================
    // Word select
    always_comb begin
        word = video_on ? clamped : blank_lvl;
        if (is_code) begin
            case (code_idx)
                2'h0: word = full_code ? `VTF_PRE_10 : `VTF_PRE_8;
                2'h3: word = {1'b1, flags, vtf_pkg::vtf_protect(flags), 2'h0};
                default: word = `VTF_ZERO;
            endcase
        end
    end
endmodule : vtf_word_fmt

`default_nettype wire

// ### include/vtf_defines.svh
/*
 Constants of the video timing formatter: line and field timing, levels, register map.
 Assumes it is included by its bare name; definitions only.
*/
`ifndef VTF_DEFINES_SVH
`define VTF_DEFINES_SVH

// Line timing in sample clocks
`define VTF_LINE_1125      12'h898
`define VTF_LINE_1250      12'h900
`define VTF_BLANK_1125     12'h118
`define VTF_BLANK_1250     12'h180
`define VTF_EAV_LEAD_1125  12'h058
`define VTF_EAV_LEAD_1250  12'h080
`define VTF_SAV_LAG_1125   12'h0c0
`define VTF_SAV_LAG_1250   12'h100
`define VTF_ACTIVE_LEN     12'h780
`define VTF_CODE_LEN       12'h004

// Field timing in line numbers
`define VTF_FIRST_LINE     11'h001
`define VTF_F1_ACT_1125    11'h029
`define VTF_F1_END_1125    11'h22d
`define VTF_F2_START_1125  11'h234
`define VTF_F2_ACT_1125    11'h25b
`define VTF_F2_END_1125    11'h460
`define VTF_LAST_1125      11'h465
`define VTF_F1_ACT_1250    11'h02d
`define VTF_F1_END_1250    11'h26c
`define VTF_F2_START_1250  11'h272
`define VTF_F2_ACT_1250    11'h29e
`define VTF_F2_END_1250    11'h4dd
`define VTF_LAST_1250      11'h4e2

// Word levels
`define VTF_BLACK          10'h040
`define VTF_ACHROM         10'h200
`define VTF_VID_MIN        10'h004
`define VTF_VID_MAX        10'h3fb
`define VTF_PRE_10         10'h3ff
`define VTF_PRE_8          10'h3fc
`define VTF_ZERO           10'h000

// Register map
`define VTF_REG_CTRL       4'h0
`define VTF_REG_STAT       4'h4
`define VTF_CTRL_W         4
`define VTF_RESP_OKAY      2'h0
`define VTF_RESP_SLVERR    2'h2

`endif

// ### include/vtf_pkg.sv
/*
 Types shared by the video timing formatter files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package vtf_pkg;
    typedef struct packed {
        logic [9:0] y_g;
        logic [9:0] cb_b;
        logic [9:0] cr_r;
    } vtf_pix_t;

    typedef struct packed {
        logic [9:0] x_ch;
        logic [9:0] c_ch;
        logic [9:0] y_ch;
    } vtf_link_t;

    typedef struct packed {
        logic rgb;
        logic ten_bit;
        logic sys1250;
        logic enable;
    } vtf_cfg_t;

    typedef struct packed {
        logic f;
        logic v;
        logic h;
    } vtf_flags_t;

    typedef enum logic [1:0] {SEG_EAV, SEG_BLANK, SEG_SAV, SEG_ACTIVE} vtf_seg_t;

    function automatic logic [3:0] vtf_protect(input vtf_flags_t fl);
        vtf_protect = {fl.v ^ fl.h, fl.f ^ fl.h, fl.f ^ fl.v, fl.f ^ fl.v ^ fl.h};
    endfunction : vtf_protect
endpackage : vtf_pkg

`default_nettype wire

// ### test/hd_video_timing_formatter_tb_top.sv
/*
 Testbench: register access, then line timing and codes in three configurations.
 Assumes the formatter, its package and the destination model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module hd_video_timing_formatter_tb_top;
    logic               ref_clk = 1'b0;
    logic               rst_b = 1'b0;
    logic [3:0]         awaddr = 4'h0;
    logic [3:0]         araddr = 4'h0;
    logic [3:0]         wstrb = 4'hf;
    logic               awvalid = 1'b0;
    logic               wvalid = 1'b0;
    logic               bready = 1'b0;
    logic               arvalid = 1'b0;
    logic               rready = 1'b0;
    logic [31:0]        wdata = 32'h0;
    vtf_pkg::vtf_pix_t  pix_in = 30'h0;
    wire logic          awready, wready, bvalid, arready, rvalid, vid_req, link_clk, sync_ref;
    wire logic [1:0]    bresp, rresp;
    wire logic [31:0]   rdata;
    wire vtf_pkg::vtf_link_t link_data;
    int                 fails = 0;
    int                 num_checks = 0;
    int                 codes, prot_err;

    initial forever #50 ref_clk = ~ref_clk;

    vtf_formatter dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pix_in(pix_in), .vid_req(vid_req), .link_data(link_data), .link_clk(link_clk),
        .sync_ref(sync_ref));
    vtf_dest_model mdl_u (.ref_clk(ref_clk), .rst_b(rst_b), .link_data(link_data), .codes(codes),
        .prot_err(prot_err));

    // ==========================================
    // Checking and closing
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    // ==========================================
    // Bus master; waits bounded, no fixed latency assumed
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n == 50) begin fails++; stop_test; end
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n == 50) begin fails++; stop_test; end
    endtask : rd

    // ==========================================
    // Scenarios
    task automatic regs_test;
        logic [31:0] d;
        logic [1:0]  r;
        rd(4'h0, d, r); chk("ctrl rst", d, 32'h0);
        chk("ctrl rst resp", r, 2'h0);
        rd(4'h8, d, r); chk("unmapped rd", d, 32'h0);
        chk("unmapped rresp", r, 2'h2);
        wr(4'hc, 32'h5, r); chk("unmapped wr", r, 2'h2);
        wr(4'h4, 32'h5, r); chk("stat wr", r, 2'h0);
        // Low byte lane off: control must stay disabled
        wstrb <= 4'he;
        wr(4'h0, 32'h5, r); chk("strb wr", r, 2'h0);
        wstrb <= 4'hf;
        rd(4'h0, d, r); chk("ctrl kept", d, 32'h0);
    endtask : regs_test

    // Line 1 is field blanking: F=0 V=1, so flag words are fixed
    task automatic run_cfg(input logic [31:0] cfg, input logic [9:0] pre, input int len, input int blk,
                           input int lead, input logic [9:0] cblk);
        int c, cs, vr;
        logic [31:0] d;
        logic [1:0]  r;
        cs = 0;
        vr = 0;
        wr(4'h0, cfg, r);
        for (c = 0; c < 3000 && link_data.y_ch !== pre; c++) @(negedge ref_clk);
        if (c == 3000) begin fails++; stop_test; end
        chk("eav c", link_data.c_ch, pre);
        chk("eav x", link_data.x_ch, cfg[3] ? pre : 10'h000);
        @(negedge ref_clk); chk("eav w1", link_data.y_ch, 10'h000);
        @(negedge ref_clk); chk("eav w2", link_data.y_ch, 10'h000);
        @(negedge ref_clk); chk("eav flag", link_data.y_ch, 10'h2d8);
        for (c = 4; c < len; c++) begin
            @(negedge ref_clk);
            if (sync_ref === 1'b1) cs = c;
            if (vid_req !== 1'b0) vr = 1;
            if (c == 10) chk("blank", {link_clk, link_data.y_ch, link_data.c_ch}, {1'b1, 10'h040, cblk});
            if (c == 11) chk("link clk", link_clk, 1'b0);
            if (c == blk - 4) chk("sav w0", link_data.y_ch, pre);
            if (c == blk - 1) chk("sav flag", link_data.y_ch, 10'h2ac);
        end
        @(negedge ref_clk); chk("line len", link_data.y_ch, pre);
        chk("sync", cs, lead);
        chk("no video", vr, 0);
        rd(4'h4, d, r); chk("status", d & 32'h707ff, 32'h60002);
        wr(4'h0, 32'h0, r);
        repeat (2) @(negedge ref_clk);
        chk("idle", link_data, 30'h0);
    endtask : run_cfg

    // Line 41 is the first video line; 8-bit shows the cleared fraction
    task automatic video_test;
        int          c, n;
        logic [1:0]  r;
        wr(4'h0, 32'h1, r);
        pix_in <= {10'h3ff, 10'h001, 10'h155};
        for (c = 0; c < 90000 && vid_req !== 1'b1; c++) @(negedge ref_clk);
        if (c == 90000) begin fails++; stop_test; end
        @(negedge ref_clk);
        chk("cb word", {link_clk, link_data}, {1'b1, 10'h000, 10'h004, 10'h3f8});
        @(negedge ref_clk);
        chk("cr word", {link_clk, link_data.c_ch}, {1'b0, 10'h154});
        for (n = 3; n < 2000; n++) begin
            @(negedge ref_clk);
            if (vid_req !== 1'b1) break;
        end
        chk("active len", n, 1920);
        @(negedge ref_clk); chk("eav after", link_data.y_ch, 10'h3fc);
        wr(4'h0, 32'h0, r);
    endtask : video_test

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        regs_test;
        run_cfg(32'h5, 10'h3ff, 2200, 280, 88, 10'h200);
        run_cfg(32'h3, 10'h3ff, 2304, 384, 128, 10'h200);
        run_cfg(32'h9, 10'h3fc, 2200, 280, 88, 10'h040);
        chk("codes", codes, 9);
        video_test;
        chk("prot", prot_err, 0);
        stop_test;
    end
endmodule : hd_video_timing_formatter_tb_top

`default_nettype wire

// ### test/vtf_dest_model.sv
/*
 Link destination model: decodes timing codes, counts them, checks protection bits.
 Assumes one link word per rising ref_clk edge; it only listens.
*/
`timescale 1ns/1ps
`default_nettype none

module vtf_dest_model (
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    input  wire vtf_pkg::vtf_link_t link_data,
    output var int                  codes,
    output var int                  prot_err
);
    logic [9:0] w1;
    logic [9:0] w2;
    logic [9:0] w3;
    logic [2:0] fvh;

    // ==========================================
    // Decoder, receive only, no return path
    assign fvh = link_data.y_ch[8:6];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            w1 <= 10'h000;
            w2 <= 10'h000;
            w3 <= 10'h000;
            codes <= 0;
            prot_err <= 0;
        end else begin
            w1 <= link_data.y_ch;
            w2 <= w1;
            w3 <= w2;
            // Top eight bits only, so 8-bit codes decode too
            if (w3[9:2] == 8'hff && w2 == 10'h000 && w1 == 10'h000) begin
                codes <= codes + 1;
                if (link_data.y_ch[5:2] != {fvh[1] ^ fvh[0], fvh[2] ^ fvh[0], fvh[2] ^ fvh[1], ^fvh}) begin
                    prot_err <= prot_err + 1;
                end
            end
        end
    end
endmodule : vtf_dest_model

`default_nettype wire
